// ==== core/event_in_cond.sv ====
`timescale 1ns/10ps
`default_nettype none
module event_in_cond (
	input wire logic clk,
	input wire logic nrst,
	input wire logic raw,
	input wire logic enable,
	input wire logic invert,
	output logic level_q,
	output logic rise_q
);
	logic cond;
	logic level_d;
	logic rise_d;

	always_comb begin
		cond = enable & (raw ^ invert);
		level_d = cond;
		rise_d = cond & ~level_q;
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			level_q <= 1'b0;
			rise_q <= 1'b0;
		end else begin
			level_q <= level_d;
			rise_q <= rise_d;
		end
	end

	in_gate_a: assert property (@(posedge clk) disable iff (!nrst)
		!enable |=> !level_q && !rise_q)
		else $error("disabled event input passed");
	in_invert_a: assert property (@(posedge clk) disable iff (!nrst)
		enable && invert |=> level_q == !$past(raw))
		else $error("event inversion wrong");
endmodule
`default_nettype wire

// ==== core/event_out_gate.sv ====
`timescale 1ns/10ps
`default_nettype none
module event_out_gate (
	input wire logic clk,
	input wire logic nrst,
	input wire logic enable,
	input wire logic hit,
	output logic evt_q
);
	logic evt_d;

	always_comb begin
		evt_d = enable & hit;
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			evt_q <= 1'b0;
		end else begin
			evt_q <= evt_d;
		end
	end
endmodule
`default_nettype wire

// ==== core/timer_event_irq_enable_ctrl.sv ====
`timescale 1ns/10ps
`default_nettype none
module timer_event_irq_enable_ctrl (
	input wire logic clk,
	input wire logic nrst,
	input wire logic [7:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [3:0] byteenable,
	input wire logic [31:0] writedata,
	output logic [31:0] readdata,
	output logic waitrequest,
	input wire logic [1:0] event_in,
	input wire evt_ctrl_pkg::counter_status_t status,
	output evt_ctrl_pkg::evt_action_t action,
	output evt_ctrl_pkg::evt_out_t event_out,
	output logic cycle_irq_point,
	output logic [31:0] irq_enable
);
	import evt_ctrl_pkg::*;

	// ------------------------------------------------------------
	// Bus slave
	// ------------------------------------------------------------
	// Every access waits exactly one cycle; readdata is built in the
	// waiting cycle so it can come from a flop.
	logic wait_q, wait_d;
	logic [31:0] rdata_q, rdata_d;
	logic [31:0] evctl_q, evctl_d;
	logic [31:0] ien_q, ien_d;
	logic [31:0] wmask;
	logic [31:0] wbits;
	logic wr_go;

	always_comb begin
		wmask = {{8{byteenable[3]}}, {8{byteenable[2]}},
			{8{byteenable[1]}}, {8{byteenable[0]}}};
		wr_go = write & ~wait_q;
		wbits = writedata & wmask & IEN_MASK;
		wait_d = ~((read | write) & wait_q);
		rdata_d = rdata_q;
		if (read & wait_q) begin
			case (address)
				EVCTL_OFS: rdata_d = evctl_q;
				IEN_CLR_OFS: rdata_d = ien_q;
				IEN_SET_OFS: rdata_d = ien_q;
				default: rdata_d = 32'h00000000;
			endcase
		end
		evctl_d = evctl_q;
		ien_d = ien_q;
		if (wr_go) begin
			case (address)
				EVCTL_OFS: evctl_d = ((evctl_q & ~wmask) | (writedata & wmask)) & EVCTL_MASK;
				IEN_CLR_OFS: ien_d = ien_q & ~wbits;
				// Set and clear sit at different offsets, so one access never does both
				IEN_SET_OFS: ien_d = ien_q | wbits;
				default: ien_d = ien_q;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			wait_q <= 1'b1;
			rdata_q <= 32'h00000000;
			evctl_q <= EVCTL_RST;
			ien_q <= IEN_RST;
		end else begin
			wait_q <= wait_d;
			rdata_q <= rdata_d;
			evctl_q <= evctl_d;
			ien_q <= ien_d;
		end
	end

	assign waitrequest = wait_q;
	assign readdata = rdata_q;
	assign irq_enable = ien_q;

	// ------------------------------------------------------------
	// Input side
	// ------------------------------------------------------------
	logic [1:0] lvl;
	logic [1:0] rise;
	logic [2:0] code0, code1;
	logic inputs_off;

	for (genvar i = 0; i < 2; i++) begin : g_in
		event_in_cond u_cond (
			.clk(clk),
			.nrst(nrst),
			.raw(event_in[i]),
			.enable(evctl_q[EV_IN_EN_LSB + i]),
			.invert(evctl_q[EV_IN_INV_LSB + i]),
			.level_q(lvl[i]),
			.rise_q(rise[i])
		);
	end

	evt_action_t act_q, act_d;

	always_comb begin
		code0 = evctl_q[ACT0_LSB +: 3];
		code1 = evctl_q[ACT1_LSB +: 3];
		inputs_off = ~evctl_q[EV_IN_EN_LSB] & ~evctl_q[EV_IN_EN_LSB + 1];
		// Edges come from the conditioned line, so flipping the invert bit
		// while a line is steady is itself seen as an event when it takes the conditioned line high.
		act_d = '0;
		case (code0)
			ACT_RETRIG: act_d.retrigger = rise[0];
			ACT0_COUNT_EV: act_d.count_on_event = rise[0];
			ACT0_START: act_d.start = rise[0];
			ACT0_INC: act_d.increment = rise[0];
			ACT0_COUNT_ASYNC: act_d.count_level = lvl[0];
			ACT_FAULT: act_d.hard_fault[0] = rise[0];
			default: act_d.count_level = 1'b0;
		endcase
		case (code1)
			ACT_RETRIG: act_d.retrigger = act_d.retrigger | rise[1];
			ACT1_DIR: act_d.dir_level = lvl[1];
			ACT1_STOP: act_d.stop = rise[1];
			ACT1_DECR: act_d.decrement_on_event = rise[1];
			ACT1_CAP_PW: act_d.period_then_width_capture = rise[1];
			ACT1_CAP_WP: act_d.width_then_period_capture = rise[1];
			ACT_FAULT: act_d.hard_fault[1] = rise[1];
			default: act_d.dir_level = 1'b0;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			act_q <= '0;
		end else begin
			act_q <= act_d;
		end
	end

	assign action = act_q;

	// ------------------------------------------------------------
	// Output side
	// ------------------------------------------------------------
	// BETWEEN marks the seam of two cycles, so the last end is skipped.
	cycle_point_t sel;
	logic hit;
	logic hit_q;

	always_comb begin
		sel = cycle_point_t'(evctl_q[CYC_SEL_LSB +: 2]);
		case (sel)
			PT_BEGIN: hit = status.cycle_begin;
			PT_END: hit = status.cycle_end;
			PT_BETWEEN: hit = status.cycle_end & ~status.last_cycle;
			PT_BOUNDARY: hit = (status.cycle_begin & status.first_cycle)
				| (status.cycle_end & status.last_cycle);
			default: hit = 1'b0;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			hit_q <= 1'b0;
		end else begin
			hit_q <= hit;
		end
	end

	assign cycle_irq_point = hit_q;

	event_out_gate u_cyc (
		.clk(clk),
		.nrst(nrst),
		.enable(evctl_q[CYC_EO_BIT]),
		.hit(hit),
		.evt_q(event_out.cycle)
	);
	event_out_gate u_trg (
		.clk(clk),
		.nrst(nrst),
		.enable(evctl_q[RETRIG_EO_BIT]),
		.hit(status.retrigger),
		.evt_q(event_out.retrigger)
	);
	event_out_gate u_wrap (
		.clk(clk),
		.nrst(nrst),
		.enable(evctl_q[WRAP_EO_BIT]),
		.hit(status.wrap),
		.evt_q(event_out.wrap)
	);

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	cycle_gate_a: assert property (
		event_out.cycle |-> $past(evctl_q[CYC_EO_BIT]) && hit_q)
		else $error("cycle event while disabled");
	retrig_out_a: assert property (
		event_out.retrigger == $past(evctl_q[RETRIG_EO_BIT] & status.retrigger))
		else $error("retrigger event wrong");
	wrap_out_a: assert property (
		evctl_q[WRAP_EO_BIT] && status.wrap |=> event_out.wrap)
		else $error("wrap event missing");
	point_begin_a: assert property (
		sel == PT_BEGIN && evctl_q[CYC_EO_BIT] && status.cycle_begin |=> event_out.cycle)
		else $error("begin point missed");
	fault_one_a: assert property (
		code1 == ACT_FAULT && rise[1] |=> action.hard_fault[1])
		else $error("input one fault missing");
	capture_order_a: assert property (
		code1 == ACT1_CAP_WP && rise[1] |=> action.width_then_period_capture
			&& !action.period_then_width_capture)
		else $error("capture order wrong");
	fault_zero_a: assert property (
		code0 == ACT_FAULT && rise[0] |=> action.hard_fault[0])
		else $error("input zero fault missing");
	reserved_code_a: assert property (
		code0 == ACT0_RSVD |=> !action.count_level && !action.increment)
		else $error("reserved code acted");
	clear_bit_a: assert property (
		wr_go && address == IEN_CLR_OFS && byteenable[2] && writedata[16]
			|=> !ien_q[16])
		else $error("clear did not disable");
	share_read_a: assert property (
		read && wait_q && (address == IEN_CLR_OFS || address == IEN_SET_OFS)
			|=> readdata == $past(ien_q) && !waitrequest)
		else $error("enable read mismatch");
	reset_zero_a: assert property (
		@(posedge clk) disable iff (1'b0) !nrst |=> ien_q == 32'h00000000)
		else $error("enables not zero after reset");
	wait_once_a: assert property (
		(read || write) && wait_q |=> !waitrequest ##1 waitrequest)
		else $error("bus answer timing wrong");

	// Enable register bookkeeping
	clear_all_a: assert property (
		wr_go && address == IEN_CLR_OFS |=> (ien_q & $past(wbits)) == 32'h00000000)
		else $error("clear left a source enabled");
	clear_zero_a: assert property (
		wr_go && address == IEN_CLR_OFS |=> (ien_q & ~$past(ien_q)) == 32'h00000000)
		else $error("clear write enabled a source");
	set_bits_a: assert property (
		wr_go && address == IEN_SET_OFS |=> (ien_q & $past(wbits)) == $past(wbits))
		else $error("set did not enable");
	unused_zero_a: assert property (
		(ien_q & ~IEN_MASK) == 32'h00000000)
		else $error("unused enable bit set");

	// Event paths
	wrap_quiet_a: assert property (
		!evctl_q[WRAP_EO_BIT] |=> !event_out.wrap)
		else $error("wrap event while disabled");
	point_mirror_a: assert property (
		event_out.cycle |-> cycle_irq_point)
		else $error("cycle event off its point");
	between_point_a: assert property (
		sel == PT_BETWEEN && status.last_cycle |=> !cycle_irq_point)
		else $error("between point on last cycle");
	dir_level_a: assert property (
		code1 == ACT1_DIR |=> action.dir_level == $past(lvl[1]))
		else $error("direction level wrong");
	count_level_a: assert property (
		code0 == ACT0_COUNT_ASYNC |=> action.count_level == $past(lvl[0]))
		else $error("count level wrong");
	in_off_a: assert property (
		!evctl_q[EV_IN_EN_LSB] |=> !lvl[0])
		else $error("disabled input zero seen");
	act_gate_a: assert property (
		inputs_off ##1 inputs_off |=> action == '0)
		else $error("disabled inputs acted");

	cover_period_c: cover property (code1 == ACT1_CAP_PW && rise[1]
		##1 action.period_then_width_capture);
	cover_bound_c: cover property (sel == PT_BOUNDARY ##0 hit);
	cover_set_clr_c: cover property (ien_q[0] ##[1:20] !ien_q[0]);
	cover_async_c: cover property (action.count_level [*3]);
endmodule
`default_nettype wire

// ==== inc/evt_ctrl_pkg.sv ====
`default_nettype none
package evt_ctrl_pkg;

	// ------------------------------------------------------------
	// Register map (byte addresses, word aligned)
	// ------------------------------------------------------------
	localparam logic [7:0] EVCTL_OFS = 8'h20;
	localparam logic [7:0] IEN_CLR_OFS = 8'h24;
	localparam logic [7:0] IEN_SET_OFS = 8'h28;
	localparam logic [31:0] EVCTL_RST = 32'h00000000;
	localparam logic [31:0] EVCTL_MASK = 32'h0000F7FF;
	localparam logic [31:0] IEN_RST = 32'h00000000;
	localparam logic [31:0] IEN_MASK = 32'h000FF80F;

	// ------------------------------------------------------------
	// Event control field positions
	// ------------------------------------------------------------
	localparam int EV_IN_EN_LSB = 14;
	localparam int EV_IN_INV_LSB = 12;
	localparam int CYC_EO_BIT = 10;
	localparam int RETRIG_EO_BIT = 9;
	localparam int WRAP_EO_BIT = 8;
	localparam int CYC_SEL_LSB = 6;
	localparam int ACT1_LSB = 3;
	localparam int ACT0_LSB = 0;

	// ------------------------------------------------------------
	// Modes and action codes
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		PT_BEGIN = 2'h0,
		PT_END = 2'h1,
		PT_BETWEEN = 2'h2,
		PT_BOUNDARY = 2'h3
	} cycle_point_t;

	localparam logic [2:0] ACT_OFF = 3'h0;
	localparam logic [2:0] ACT_RETRIG = 3'h1;
	localparam logic [2:0] ACT0_COUNT_EV = 3'h2;
	localparam logic [2:0] ACT0_START = 3'h3;
	localparam logic [2:0] ACT0_INC = 3'h4;
	localparam logic [2:0] ACT0_COUNT_ASYNC = 3'h5;
	localparam logic [2:0] ACT0_RSVD = 3'h6;
	localparam logic [2:0] ACT1_DIR = 3'h2;
	localparam logic [2:0] ACT1_STOP = 3'h3;
	localparam logic [2:0] ACT1_DECR = 3'h4;
	localparam logic [2:0] ACT1_CAP_PW = 3'h5;
	localparam logic [2:0] ACT1_CAP_WP = 3'h6;
	localparam logic [2:0] ACT_FAULT = 3'h7;

	// Counter core status pulses feeding the output side
	typedef struct packed {
		logic cycle_begin;
		logic cycle_end;
		logic first_cycle;
		logic last_cycle;
		logic retrigger;
		logic wrap;
	} counter_status_t;

	// Decoded actions towards the counter core
	typedef struct packed {
		logic retrigger;
		logic start;
		logic stop;
		logic count_on_event;
		logic increment;
		logic decrement_on_event;
		logic dir_level;
		logic count_level;
		logic period_then_width_capture;
		logic width_then_period_capture;
		logic [1:0] hard_fault;
	} evt_action_t;

	typedef struct packed {
		logic cycle;
		logic retrigger;
		logic wrap;
	} evt_out_t;

endpackage
`default_nettype wire

// ==== test/evt_far_end.sv ====
`timescale 1ns/10ps
`default_nettype none
module evt_far_end
	import evt_ctrl_pkg::*;
(
	input wire logic clk,
	output logic [1:0] event_in,
	output evt_ctrl_pkg::counter_status_t status
);
	// ----------------------------------------
	// Event channels hold levels; status pulses
	// ----------------------------------------
	initial begin
		event_in = 2'h0;
		status = '0;
	end
	task automatic line(input int n, input logic v);
		@(posedge clk) event_in[n] <= v;
	endtask
	// Counter core pulses last one cycle only, as the real core does
	task automatic pulse(input counter_status_t s);
		@(posedge clk) status <= s;
		@(posedge clk) status <= '0;
	endtask
endmodule
`default_nettype wire

// ==== test/timer_event_irq_enable_ctrl_bench.sv ====
`timescale 1ns/10ps
`default_nettype none
module timer_event_irq_enable_ctrl_bench;
	import evt_ctrl_pkg::*;
	logic clk, nrst, read, write, waitrequest, cyc_pt;
	logic [7:0] address;
	logic [3:0] byteenable;
	logic [31:0] writedata, readdata, irq_enable, q;
	logic [1:0] event_in;
	counter_status_t status;
	evt_action_t action;
	evt_out_t event_out;
	int error_cnt = 0;
	int checks = 0;
	timer_event_irq_enable_ctrl u_timer_event_irq_enable_ctrl (.clk(clk), .nrst(nrst),
		.address(address), .read(read), .write(write), .byteenable(byteenable),
		.writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
		.event_in(event_in), .status(status), .action(action), .event_out(event_out),
		.cycle_irq_point(cyc_pt), .irq_enable(irq_enable));
	evt_far_end u_evt_far_end (.clk(clk), .event_in(event_in), .status(status));
	// ----------------------------------------
	// Shared helpers
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// Request held until waitrequest is seen low at a rising edge; only the watchdog ends a wait
	task automatic acc(input logic [7:0] a, input logic wr, input logic [31:0] d,
		input logic [3:0] be);
		@(posedge clk);
		address <= a;
		write <= wr;
		read <= !wr;
		writedata <= d;
		byteenable <= be;
		do begin
			@(posedge clk);
		end while (waitrequest !== 1'b0);
		q = readdata;
		read <= 1'b0;
		write <= 1'b0;
	endtask
	function automatic evt_action_t ex(input int i, input logic [2:0] c);
		evt_action_t e;
		e = '0;
		case (c)
			3'h1: e.retrigger = 1'b1;
			3'h2: if (i == 0) e.count_on_event = 1'b1; else e.dir_level = 1'b1;
			3'h3: if (i == 0) e.start = 1'b1; else e.stop = 1'b1;
			3'h4: if (i == 0) e.increment = 1'b1; else e.decrement_on_event = 1'b1;
			3'h5: if (i == 0) e.count_level = 1'b1; else e.period_then_width_capture = 1'b1;
			3'h6: e.width_then_period_capture = 1'b1;
			3'h7: e.hard_fault[i] = 1'b1;
			default: e = '0;
		endcase
		return e;
	endfunction
	task automatic rst();
		@(posedge clk);
		nrst <= 1'b0;
		repeat (11) @(posedge clk);
		nrst <= 1'b1;
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset();
		logic [7:0] al[4] = '{EVCTL_OFS, IEN_CLR_OFS, IEN_SET_OFS, 8'h2C};
		foreach (al[k]) begin
			acc(al[k], 1'b0, 32'h0, 4'hF);
			chk(q, 32'h00000000);
		end
		chk(irq_enable, IEN_RST);
	endtask
	task automatic t_enable();
		int bl[13] = '{19, 18, 17, 16, 15, 14, 13, 12, 11, 3, 2, 1, 0};
		logic [31:0] e;
		acc(IEN_SET_OFS, 1'b1, 32'hFFFFFFFF, 4'h1);
		acc(IEN_CLR_OFS, 1'b0, 32'h0, 4'hF);
		chk(q, 32'h0000000F);
		acc(IEN_SET_OFS, 1'b1, 32'hFFFFFFFF, 4'hF);
		acc(IEN_CLR_OFS, 1'b1, 32'h0, 4'hF);
		acc(IEN_CLR_OFS, 1'b0, 32'h0, 4'hF);
		chk(q, IEN_MASK);
		e = IEN_MASK;
		foreach (bl[k]) begin
			e[bl[k]] = 1'b0;
			acc(IEN_CLR_OFS, 1'b1, 32'h1 << bl[k], 4'hF);
			#1 chk(irq_enable, e);
			acc(IEN_SET_OFS, 1'b0, 32'h0, 4'hF);
			chk(q, e);
		end
	endtask
	task automatic t_inputs();
		for (int i = 0; i < 2; i++) begin
			for (int c = 0; c < 8; c++) begin
				if (i == 0 && c == 6) continue;
				acc(EVCTL_OFS, 1'b1, (32'h1 << (14 + i)) | (32'(c) << (3 * i)), 4'hF);
				u_evt_far_end.line(i, 1'b1);
				repeat (2) @(posedge clk);
				#1 chk({20'h0, action}, {20'h0, ex(i, 3'(c))});
				u_evt_far_end.line(i, 1'b0);
				repeat (3) @(posedge clk);
			end
			acc(EVCTL_OFS, 1'b1, 32'h9, 4'hF);
			u_evt_far_end.line(i, 1'b1);
			repeat (2) @(posedge clk);
			#1 chk({20'h0, action}, 32'h0);
			u_evt_far_end.line(i, 1'b0);
		end
		acc(EVCTL_OFS, 1'b1, 32'h5001, 4'hF);
		repeat (4) @(posedge clk);
		u_evt_far_end.line(0, 1'b1);
		repeat (2) @(posedge clk);
		#1 chk({20'h0, action}, 32'h0);
		u_evt_far_end.line(0, 1'b0);
		repeat (2) @(posedge clk);
		#1 chk({20'h0, action}, {20'h0, ex(0, 3'h1)});
	endtask
	task automatic t_outputs();
		counter_status_t s;
		logic b, f, l, h;
		for (int en = 0; en < 2; en++) begin
			for (int sel = 0; sel < 4; sel++) begin
				acc(EVCTL_OFS, 1'b1, (32'(en) * 32'h700) | (32'(sel) << 6), 4'hF);
				for (int p = 0; p < 4; p++) begin
					b = (p == 0 || p == 2);
					f = (p == 2);
					l = (p == 3);
					s = {b, !b, f, l, p[0], p[1]};
					h = sel == 0 ? b : sel == 1 ? !b : sel == 2 ? (!b && !l) : ((b && f) || l);
					u_evt_far_end.pulse(s);
					#1 chk({cyc_pt, event_out}, {h, h & en[0], p[0] & en[0], p[1] & en[0]});
				end
			end
		end
	endtask
	task automatic end_of_test();
		if (error_cnt == 0 && checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// ----------------------------------------
	// Clock, sequence and watchdog
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	initial begin
		nrst = 1'b0;
		read = 1'b0;
		write = 1'b0;
		address = 8'h00;
		byteenable = 4'h0;
		writedata = 32'h0;
		rst();
		t_reset();
		t_enable();
		acc(EVCTL_OFS, 1'b1, 32'hFFFFFFFF, 4'hF);
		acc(EVCTL_OFS, 1'b0, 32'h0, 4'hF);
		chk(q, EVCTL_MASK);
		t_inputs();
		t_outputs();
		rst();
		t_reset();
		end_of_test();
	end
	initial begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		end_of_test();
	end
endmodule
`default_nettype wire
